// file: mior_pkg.sv
// mior_pkg: constants of the mixed i/o register bank.
// assumes a 125 MHz clock and a byte-offset register port.
package mior_pkg;
    localparam int unsigned CLK_NS = 8;
    localparam int unsigned AW     = 5;
    localparam int unsigned DW     = 16;

    // register offsets
    localparam logic [4:0] OFS_IO_STATUS   = 5'h00;
    localparam logic [4:0] OFS_OUT_SWITCH  = 5'h02;
    localparam logic [4:0] OFS_AIN_VALUE   = 5'h08;
    localparam logic [4:0] OFS_AOUT_VALUE  = 5'h0a;
    localparam logic [4:0] OFS_LATCH_ACK   = 5'h12;
    localparam logic [4:0] OFS_FILTER_CFG  = 5'h16;
    localparam logic [4:0] OFS_MODE_CFG    = 5'h18;
    localparam logic [4:0] OFS_LOW_CLAMP   = 5'h1a;
    localparam logic [4:0] OFS_HIGH_CLAMP  = 5'h1c;
    localparam logic [4:0] OFS_MON_CODE    = 5'h1f;

    // field positions
    localparam int unsigned FLT_LEVEL_LSB = 0;
    localparam int unsigned FLT_RAMP_LSB  = 4;
    localparam int unsigned MODE_AIN_LSB  = 0;
    localparam int unsigned MODE_AOUT_BIT = 4;
    localparam int unsigned STAT_IN_LSB   = 0;
    localparam int unsigned STAT_FLT_LSB  = 4;

    // reset values
    localparam logic [7:0]  RST_FILTER_CFG = 8'h00;
    localparam logic [7:0]  RST_MODE_CFG   = 8'h00;
    localparam logic [15:0] RST_LOW_CLAMP  = 16'h8000;
    localparam logic [15:0] RST_HIGH_CLAMP = 16'h7fff;

    // analog input ranges
    localparam logic [1:0] AIN_VOLT   = 2'b00;
    localparam logic [1:0] AIN_I0_20  = 2'b01;
    localparam logic [1:0] AIN_I4_20  = 2'b11;

    // monitoring codes
    localparam logic [1:0] MON_OK     = 2'b00;
    localparam logic [1:0] MON_LOW    = 2'b01;
    localparam logic [1:0] MON_HIGH   = 2'b10;
    localparam logic [1:0] MON_OPEN   = 2'b11;

    // timing
    localparam int unsigned OUT_DELAY_NS   = 50000;
    localparam int unsigned OUT_DELAY_CYC  = OUT_DELAY_NS / CLK_NS;
    localparam int unsigned SAMPLE_OFS_NS  = 20000;
    localparam int unsigned SAMPLE_OFS_CYC = SAMPLE_OFS_NS / CLK_NS;
    localparam int unsigned DIG_MIN_NS     = 150000;
    localparam int unsigned DIG_FMIN_NS    = 200000;
    localparam int unsigned ANA_MIN_NS     = 400000;
    localparam int unsigned ANA_FMIN_NS    = 1000000;
    localparam int unsigned DIG_MIN_CYC    = (DIG_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned DIG_FMIN_CYC   = (DIG_FMIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ANA_MIN_CYC    = (ANA_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ANA_FMIN_CYC   = (ANA_FMIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TW             = 18;
endpackage : mior_pkg

// file: mior_regs.sv
// mior_regs: register bank of the mixed digital/analog i/o module.
// assumes a register port synchronous to i_mclk and one-cycle sync pulses.
`timescale 1ns/10ps
module mior_regs
    import mior_pkg::*;
#(
    parameter int unsigned P_OUT_DELAY = mior_pkg::OUT_DELAY_CYC,
    parameter int unsigned P_DIG_MIN   = mior_pkg::DIG_MIN_CYC,
    parameter int unsigned P_DIG_FMIN  = mior_pkg::DIG_FMIN_CYC,
    parameter int unsigned P_ANA_MIN   = mior_pkg::ANA_MIN_CYC,
    parameter int unsigned P_ANA_FMIN  = mior_pkg::ANA_FMIN_CYC
) (
    input  wire logic                  i_mclk,        // 125 MHz clock
    input  wire logic                  i_rst_n,       // sync reset, active low
    input  wire logic [mior_pkg::AW-1:0] i_reg_addr,  // byte offset
    input  wire logic                  i_reg_wr,      // write strobe
    input  wire logic [mior_pkg::DW-1:0] i_reg_wdata, // write data
    output logic      [mior_pkg::DW-1:0] o_reg_rdata, // read data, one cycle late
    input  wire logic                  i_sync,        // network_cycle_sync pulse
    input  wire logic                  i_dig_filter,  // digital input filter active
    input  wire logic [3:0]            i_in_level,    // digital input levels
    input  wire logic [1:0]            i_out_fault,   // output short/overload
    output logic      [3:0]            o_latch_clear, // latch clear pulses
    output logic      [1:0]            o_switch_out,  // switch_out_ch1/2
    output logic                       o_adc_strobe,  // sample request
    input  wire logic [15:0]           i_adc_data,    // raw analog sample
    input  wire logic                  i_open_line,   // front end open line
    output logic      [1:0]            o_ain_mode,    // input range to front end
    output logic      [15:0]           o_aout_value,  // analog_out_value
    output logic                       o_aout_current, // output is current
    output logic                       o_diag_event   // monitor change pulse
);
    import mior_pkg::*;

    function automatic logic [15:0] ramp_limit(input logic [2:0] code);
        ramp_limit = 16'h7fff >> code;
    endfunction : ramp_limit

    logic [7:0]  filter_cfg;
    logic [7:0]  mode_cfg;
    logic [15:0] low_clamp;
    logic [15:0] high_clamp;
    logic [1:0]  switch_state;
    logic [15:0] ain_value;
    logic [1:0]  mon_code;
    logic [7:0]  io_status;
    logic [TW-1:0] since_sync;
    logic [TW-1:0] out_cnt;
    logic [TW-1:0] smp_cnt;
    logic        out_run;
    logic        smp_run;
    logic [15:0] raw;
    logic        raw_vld;
    logic signed [15:0] ramped;
    logic        ramp_vld;
    logic signed [16:0] filt;
    logic        filt_vld;

    // write decode
    wire wr_out    = i_reg_wr && (i_reg_addr == OFS_OUT_SWITCH);
    wire wr_aout   = i_reg_wr && (i_reg_addr == OFS_AOUT_VALUE);
    wire wr_ack    = i_reg_wr && (i_reg_addr == OFS_LATCH_ACK);
    wire wr_filter = i_reg_wr && (i_reg_addr == OFS_FILTER_CFG);
    wire wr_mode   = i_reg_wr && (i_reg_addr == OFS_MODE_CFG);
    wire wr_low    = i_reg_wr && (i_reg_addr == OFS_LOW_CLAMP);
    wire wr_high   = i_reg_wr && (i_reg_addr == OFS_HIGH_CLAMP);

    wire [2:0] flt_level = filter_cfg[FLT_LEVEL_LSB +: 3];
    wire [2:0] ramp_code = filter_cfg[FLT_RAMP_LSB +: 3];
    wire [1:0] ain_mode  = mode_cfg[MODE_AIN_LSB +: 2];
    wire       volt_mode = (ain_mode == AIN_VOLT);

    // refresh gates: a too-short cycle skips this cycle's update
    wire [TW-1:0] dig_min = i_dig_filter ? TW'(P_DIG_FMIN) : TW'(P_DIG_MIN);
    wire [TW-1:0] ana_min = (flt_level != 3'h0) ? TW'(P_ANA_FMIN) : TW'(P_ANA_MIN);
    wire dig_ok = i_sync && (since_sync >= dig_min);
    wire ana_ok = i_sync && (since_sync >= ana_min);
    wire out_fire = out_run && (out_cnt == TW'(P_OUT_DELAY - 1));
    wire smp_fire = smp_run && (smp_cnt == TW'(SAMPLE_OFS_CYC - 1));

    // ramp step on the raw sample
    wire signed [16:0] delta = $signed({raw[15], raw}) - $signed({ramped[15], ramped});
    wire signed [16:0] rlim  = $signed({1'b0, ramp_limit(ramp_code)});
    wire signed [16:0] next_step =
        (ramp_code == 3'h0) ? delta :
        (delta > rlim) ? rlim :
        (delta < -rlim) ? -rlim : delta;
    wire signed [16:0] ramp_sum  = $signed({ramped[15], ramped}) + next_step;

    // averaging on the ramp output
    wire signed [16:0] next_filt = (flt_level == 3'h0) ? 17'(ramped) :
        filt - (filt >>> flt_level) + (17'(ramped) >>> flt_level);

    // clamp and monitor
    wire signed [16:0] lo_s = 17'($signed(low_clamp));
    wire signed [16:0] hi_s = 17'($signed(high_clamp));
    wire        open_now = i_open_line && volt_mode;
    wire [1:0]  next_code = open_now ? MON_OPEN :
                            (filt < lo_s) ? MON_LOW :
                            (filt > hi_s) ? MON_HIGH : MON_OK;
    wire signed [16:0] clamped = (next_code == MON_LOW) ? lo_s :
                                 (next_code == MON_HIGH) ? hi_s : filt;
    // 0-20 mA has no range below zero; 4-20 mA may show underrange
    wire signed [16:0] floored = (ain_mode == AIN_I0_20 && clamped < 0) ? 17'sd0 : clamped;

    // read mux
    logic [15:0] next_rdata;
    always_comb begin
        unique case (i_reg_addr)
            OFS_IO_STATUS:  next_rdata = {8'h00, io_status};
            OFS_AIN_VALUE:  next_rdata = ain_value;
            OFS_MON_CODE:   next_rdata = {14'h0000, mon_code};
            default:        next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            filter_cfg   <= RST_FILTER_CFG;
            mode_cfg     <= RST_MODE_CFG;
            low_clamp    <= RST_LOW_CLAMP;
            high_clamp   <= RST_HIGH_CLAMP;
            switch_state <= 2'h0;
            o_aout_value <= 16'h0000;
            o_latch_clear <= 4'h0;
            o_reg_rdata  <= 16'h0000;
        end else begin
            if (wr_filter) filter_cfg <= i_reg_wdata[7:0] & 8'h77;
            if (wr_mode)   mode_cfg   <= i_reg_wdata[7:0] & 8'h13;
            if (wr_low)    low_clamp  <= i_reg_wdata;
            if (wr_high)   high_clamp <= i_reg_wdata;
            if (wr_out)    switch_state <= i_reg_wdata[1:0];
            if (wr_aout)   o_aout_value <= i_reg_wdata;
            o_latch_clear <= wr_ack ? i_reg_wdata[3:0] : 4'h0;
            o_reg_rdata   <= next_rdata;
        end
    end

    // sync timing: output delay and sample offset counters
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            since_sync   <= {TW{1'b1}};
            out_run      <= 1'b0;
            out_cnt      <= '0;
            smp_run      <= 1'b0;
            smp_cnt      <= '0;
            o_switch_out <= 2'h0;
            io_status    <= 8'h00;
        end else begin
            since_sync <= i_sync ? TW'(1) :
                          (&since_sync) ? since_sync : since_sync + TW'(1);
            out_cnt <= dig_ok ? '0 : out_cnt + TW'(1);
            out_run <= dig_ok | (out_run & ~out_fire);
            smp_cnt <= ana_ok ? '0 : smp_cnt + TW'(1);
            smp_run <= ana_ok | (smp_run & ~smp_fire);
            if (out_fire) o_switch_out <= switch_state;
            io_status <= {2'b00, i_out_fault, i_in_level};
        end
    end

    // analog chain: sample, ramp, filter, clamp; done a few clocks after sample
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_adc_strobe <= 1'b0;
            raw          <= 16'h0000;
            raw_vld      <= 1'b0;
            ramped       <= 16'sh0000;
            ramp_vld     <= 1'b0;
            filt         <= 17'sh00000;
            filt_vld     <= 1'b0;
            ain_value    <= 16'h0000;
            mon_code     <= MON_OK;
            o_diag_event <= 1'b0;
        end else begin
            o_adc_strobe <= smp_fire;
            raw_vld      <= smp_fire;
            if (smp_fire) raw <= i_adc_data;
            ramp_vld     <= raw_vld;
            if (raw_vld) ramped <= ramp_sum[15:0];
            filt_vld     <= ramp_vld;
            if (ramp_vld) filt <= next_filt;
            o_diag_event <= 1'b0;
            if (filt_vld) begin
                mon_code <= next_code;
                // open line in voltage mode keeps the last good value
                if (!open_now) ain_value <= floored[15:0];
                o_diag_event <= (next_code != mon_code);
            end
        end
    end

    assign o_ain_mode     = ain_mode;
    assign o_aout_current = mode_cfg[MODE_AOUT_BIT];

    // checks
    chk_latch_clear_pulse: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        wr_ack |=> (o_latch_clear == $past(i_reg_wdata[3:0])))
        else $error("latch clear does not follow ack write");
    chk_switch_at_delay: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (o_switch_out != $past(o_switch_out)) |-> $past(out_fire))
        else $error("outputs changed away from the sync delay");
    chk_status_layout: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $past(i_rst_n) |-> (io_status == {2'b00, $past(i_out_fault), $past(i_in_level)}))
        else $error("status register layout wrong");
    chk_current_nonneg: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (filt_vld && ain_mode == AIN_I0_20 && !open_now) |=> !ain_value[15])
        else $error("negative value in 0-20 mA mode");
    chk_low_clamp_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (filt_vld && next_code == MON_LOW && ain_mode != AIN_I0_20)
        |=> (mon_code == MON_LOW && ain_value == $past(low_clamp)))
        else $error("lower limit not held");
    chk_high_clamp_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (filt_vld && next_code == MON_HIGH) |=> (ain_value == $past(high_clamp)))
        else $error("upper limit not held");
    chk_no_open_current: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (filt_vld && !volt_mode) |=> (mon_code != MON_OPEN))
        else $error("open line reported in current mode");
    chk_diag_on_change: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (mon_code != $past(mon_code)) |-> o_diag_event)
        else $error("monitor change without notification");
    chk_sample_offset: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_adc_strobe |-> ##4 (ain_value == $past(floored[15:0]) || open_now || $past(open_now)))
        else $error("sample not published");

    // register side: writes land only where decoded, reserved bits stay clear
    chk_latch_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !wr_ack |=> (o_latch_clear == 4'h0))
        else $error("latch clear pulse without ack write");

    chk_filter_reserved: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (filter_cfg[3] == 1'b0) && (filter_cfg[7] == 1'b0))
        else $error("reserved filter bits set");

    chk_mode_reserved: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (mode_cfg[3:2] == 2'h0) && (mode_cfg[7:5] == 3'h0))
        else $error("reserved mode bits set");

    chk_ain_mode_out: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_ain_mode == mode_cfg[1:0])
        else $error("input range differs from mode bits");

    chk_aout_type: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_aout_current == mode_cfg[4])
        else $error("output type differs from mode bit");

    chk_aout_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !wr_aout |=> (o_aout_value == $past(o_aout_value)))
        else $error("analog output changed without write");

    chk_mon_read_pad: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ($past(i_reg_addr) == OFS_MON_CODE) |-> (o_reg_rdata[15:2] == 14'h0000))
        else $error("monitor code upper bits not zero");

    // status byte: inputs low nibble, faults above, top bits reserved
    chk_status_reserved: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        io_status[7:6] == 2'b00)
        else $error("reserved status bits set");

    chk_fault_bits: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $past(i_rst_n) |-> (io_status[5:4] == $past(i_out_fault)))
        else $error("output fault bits misplaced");

    // outputs move only at the delayed sync point, and to the stored state
    chk_switch_value: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        out_fire |=> (o_switch_out == $past(switch_state)))
        else $error("outputs not set to stored state");

    chk_switch_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !out_fire |=> (o_switch_out == $past(o_switch_out)))
        else $error("outputs moved outside delay point");

    // too-short cycles must not restart the counters
    chk_dig_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_sync && (since_sync < dig_min)) |=> (out_cnt == $past(out_cnt) + TW'(1)))
        else $error("short cycle restarted output delay");

    chk_ana_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_sync && (since_sync < ana_min)) |=> (smp_cnt == $past(smp_cnt) + TW'(1)))
        else $error("short cycle restarted sample offset");

    chk_strobe_pulse: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_adc_strobe |=> !o_adc_strobe)
        else $error("sample strobe longer than one cycle");

    // analog chain ordering: ramp first, then averaging
    chk_ramp_chain: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        raw_vld |=> ramp_vld)
        else $error("ramp stage skipped");

    chk_ramp_off_follow: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (raw_vld && ramp_code == 3'h0) |=> (ramped == $past(raw)))
        else $error("unlimited ramp does not follow input");

    chk_ramp_step: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (raw_vld && ramp_code != 3'h0) |-> ((next_step <= rlim) && (next_step >= -rlim)))
        else $error("ramp step beyond limit");

    chk_filter_off_pass: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (ramp_vld && flt_level == 3'h0) |=> (filt == $past(17'(ramped))))
        else $error("disabled filter does not pass ramp value");

    // monitoring outcome per update
    chk_diag_pulse_only: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_diag_event |-> (mon_code != $past(mon_code)))
        else $error("notification without code change");

    chk_code_inside: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (filt_vld && !open_now && filt >= lo_s && filt <= hi_s) |=> (mon_code == MON_OK))
        else $error("code not cleared inside limits");

    chk_value_tracks: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (filt_vld && next_code == MON_OK) |=> (ain_value == $past(floored[15:0])))
        else $error("value does not track inside limits");

    // open line in voltage mode freezes the published value rather than showing garbage
    chk_open_holds: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (filt_vld && open_now) |=> (ain_value == $past(ain_value)))
        else $error("value changed during open line");
endmodule : mior_regs

// file: mior_sync_model.sv
// mior_sync_model: network cycle source standing on the controller side.
// assumes i_run is held high while cyclic exchange is wanted.
`timescale 1ns/10ps
module mior_sync_model #(
    parameter int unsigned P_PERIOD = 2600 // cycles between sync pulses
) (
    input  wire logic i_mclk,  // clock
    input  wire logic i_rst_n, // sync reset, active low
    input  wire logic i_run,   // cycle generation enable
    output logic      o_sync   // network_cycle_sync pulse
);
    logic [15:0] cnt;
    // period sits above the bench minimums of 40 to 80 cycles, but below the package default minimums
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || !i_run) begin
            cnt    <= '0;
            o_sync <= 1'b0;
        end else begin
            cnt    <= (cnt == 16'(P_PERIOD - 1)) ? 16'h0000 : cnt + 16'h0001;
            o_sync <= (cnt == 16'(P_PERIOD - 1));
        end
    end
endmodule : mior_sync_model

// file: tb.sv
// tb: self-checking bench for the mixed i/o register bank.
// assumes the sync model paces cycles just above the sample offset (2600 against 2500 cycles).
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
    import mior_pkg::*;
    localparam int unsigned DLY = 20;
    logic        i_mclk = 1'b0, i_rst_n = 1'b0, reg_wr = 1'b0, open_line = 1'b0;
    logic [4:0]  reg_addr = '0;
    logic [15:0] wdata = '0, adc = '0, r;
    logic [3:0]  in_level = '0, latch_acc = '0;
    logic [1:0]  out_fault = '0, last_code = 2'b00;
    logic        dig_filter = 1'b0, sync_run = 1'b1;
    wire  [15:0] rdata, aout;
    wire  [3:0]  latch_clr;
    wire  [1:0]  sw_out, ain_mode;
    wire         strobe, aout_cur, diag, sync;
    int          num_errors = 0, tests_run = 0, cycles = 0, diag_cnt = 0, latch_cyc = 0;
    logic [4:0]  wo_list [8] = '{OFS_OUT_SWITCH, OFS_AOUT_VALUE, OFS_LATCH_ACK, OFS_FILTER_CFG,
                                 OFS_MODE_CFG, OFS_LOW_CLAMP, OFS_HIGH_CLAMP, 5'h04};

    mior_regs #(.P_OUT_DELAY(DLY), .P_DIG_MIN(40), .P_DIG_FMIN(50), .P_ANA_MIN(60),
                .P_ANA_FMIN(80)) mior_regs_inst (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_sync(sync), .i_dig_filter(dig_filter),
        .i_in_level(in_level), .i_out_fault(out_fault), .o_latch_clear(latch_clr),
        .o_switch_out(sw_out), .o_adc_strobe(strobe), .i_adc_data(adc),
        .i_open_line(open_line), .o_ain_mode(ain_mode), .o_aout_value(aout),
        .o_aout_current(aout_cur), .o_diag_event(diag));
    mior_sync_model #(.P_PERIOD(2600)) mior_sync_model_inst (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_run(sync_run), .o_sync(sync));

    always #4 i_mclk = ~i_mclk;

    // pulse bookkeeping, since the pulses last a single cycle
    always @(posedge i_mclk) begin
        cycles++;
        if (diag === 1'b1) diag_cnt++;
        if (latch_clr !== 4'h0) begin
            latch_acc = latch_acc | latch_clr;
            latch_cyc++;
        end
        if (cycles == 60000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge i_mclk);
        reg_addr = a;
        wdata = d;
        reg_wr = 1'b1;
        @(negedge i_mclk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge i_mclk);
        reg_addr = a;
        @(negedge i_mclk);
        d = rdata;
    endtask : rd

    task automatic wait_sync();
        @(negedge i_mclk);
        while (sync !== 1'b1) @(negedge i_mclk);
    endtask : wait_sync

    // one full network cycle: present a sample, then read value and code
    task automatic ain(input logic [15:0] v, input logic ol, input logic [15:0] ev,
                       input logic [1:0] ec);
        int d0;
        logic [15:0] x;
        adc = v;
        open_line = ol;
        d0 = diag_cnt;
        wait_sync();
        repeat (2520) @(negedge i_mclk);
        rd(OFS_AIN_VALUE, x);
        `CHK("ain_value", ev, x)
        rd(OFS_MON_CODE, x);
        `CHK("mon_code", {14'h0000, ec}, x)
        `CHK("diag_count", (ec != last_code) ? 1 : 0, diag_cnt - d0)
        last_code = ec;
    endtask : ain

    initial begin
        repeat (4) @(negedge i_mclk);
        i_rst_n = 1'b1;
        foreach (wo_list[k]) begin
            rd(wo_list[k], r);
            `CHK("wo_read", 16'h0000, r)
        end
        in_level = 4'hb;
        out_fault = 2'b01;
        wr(OFS_IO_STATUS, 16'hffff);
        rd(OFS_IO_STATUS, r);
        `CHK("status_a", 16'h001b, r)
        in_level = 4'h4;
        out_fault = 2'b10;
        rd(OFS_IO_STATUS, r);
        `CHK("status_b", 16'h0024, r)
        wr(OFS_LATCH_ACK, 16'h0009);
        wr(OFS_LATCH_ACK, 16'h0000);
        repeat (3) @(negedge i_mclk);
        `CHK("latch_bits", 4'h9, latch_acc)
        `CHK("latch_cycles", 1, latch_cyc)
        for (int v = 2; v >= 1; v--) begin
            dig_filter = (v == 1);
            wr(OFS_OUT_SWITCH, 16'(v));
            wait_sync();
            repeat (DLY) @(negedge i_mclk);
            `CHK("switch_early", 2'((v == 2) ? 0 : 2), sw_out)
            @(negedge i_mclk);
            `CHK("switch_out", 2'(v), sw_out)
        end
        wr(OFS_MODE_CFG, 16'h00ff);
        wr(OFS_AOUT_VALUE, 16'h8000);
        @(negedge i_mclk);
        `CHK("ain_mode", 2'b11, ain_mode)
        `CHK("aout_current", 1'b1, aout_cur)
        `CHK("aout_value", 16'h8000, aout)
        wr(OFS_MODE_CFG, 16'h0000);
        ain(16'h8000, 1'b0, 16'h8000, MON_OK);
        ain(16'h7fff, 1'b0, 16'h7fff, MON_OK);
        wr(OFS_LOW_CLAMP, 16'h0064);
        wr(OFS_HIGH_CLAMP, 16'h07d0);
        ain(16'h0032, 1'b0, 16'h0064, MON_LOW);
        ain(16'h0bb8, 1'b0, 16'h07d0, MON_HIGH);
        ain(16'h03e8, 1'b0, 16'h03e8, MON_OK);
        ain(16'h0258, 1'b1, 16'h03e8, MON_OPEN);
        wr(OFS_MODE_CFG, 16'h0001);
        wr(OFS_LOW_CLAMP, 16'h0000);
        ain(16'hfffb, 1'b1, 16'h0000, MON_LOW);
        wr(OFS_MODE_CFG, 16'h0003);
        wr(OFS_LOW_CLAMP, 16'he000);
        ain(16'hff9c, 1'b1, 16'hff9c, MON_OK);
        wr(OFS_MODE_CFG, 16'h0000);
        wr(OFS_LOW_CLAMP, 16'h8000);
        wr(OFS_HIGH_CLAMP, 16'h7fff);
        ain(16'h0000, 1'b0, 16'h0000, MON_OK);
        wr(OFS_FILTER_CFG, 16'h0001);
        // state starts from zero, so level 1 halves the gap each cycle
        ain(16'h03e8, 1'b0, 16'h01f4, MON_OK);
        ain(16'h03e8, 1'b0, 16'h02ee, MON_OK);
        final_report();
    end
endmodule : tb
